// ===== logic/adc_ctrl.v
// Control logic of a 4-channel 10-bit successive-approximation converter
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
// Behaviour
// - Mode bit 7 runs conversion; 0 stops, 1 starts on selected channel.
// - Speed codes 000,100,110,101 give 12/36,24/72,96/144,48/96 cycles.
// - Speed codes 010,001,111,011 give 48/72,24/48,176/224,88/112 cycles.
// - Mode bit 0 enables the comparator; 0 powers it down unless run is set.
// - Run starts conversion even with comparator off; first result suspect.
// - Stop, waiting and conversion modes follow run and enable bits.
// - Mode bits 6, 2, 1 are fixed at zero.
// - Channel bits 1:0 choose input 0..3; bits 7:2 read zero.
// - Channel register takes bit and byte writes; resets to 00H.
// - Mode register takes bit and byte writes; resets to 00H.
// - On completion result goes to 10-bit and 8-bit registers, irq raised.
// - Conversions repeat back to back while run stays set.
// - Any register write aborts conversion; restart from sampling if run.
// - Bits resolve 9 down to 0; kept when input at least tap.

// ==========================================================================
// Operation overview
// Register access
//   Writes land on the rising edge that sees the write strobe.
//   Mask picks the bits that change; all ones is a byte write.
//   Reads answer on the rising edge that sees the read strobe, then hold.
//   Unmapped reads give zero; unmapped writes are dropped.
//   Fixed-zero control bits are masked on every write.
// Power states
//   Run and enable clear: comparator off, no static current.
//   Enable alone: comparator powered, sequencer waiting.
//   Run set: converting, comparator powered whatever enable holds.
//   Power follows a control write on the same edge it lands.
// Conversion sequence
//   Sampling starts on the edge after the run bit lands.
//   Sampling lasts the sample length of the current speed code.
//   Ten comparison steps follow, most significant bit first.
//   Each step gets the post-sample cycles divided by ten.
//   The remainder adds one cycle to each of the earliest steps.
//   Comparator is read in the last cycle of each step.
//   A kept bit stays set; a dropped bit clears with the next trial.
//   Result copies and the end pulse come with the last decision.
//   With run still set, sampling restarts after one idle cycle.
//   Active flag spans sampling and all ten steps, nothing more.
// Hazards
//   Any control write aborts the sequence, even with run unchanged.
//   Abort costs the partial result; results keep the last good one.
//   Abort and a last decision in one cycle: the abort wins.
//   A result started with an unsettled comparator is not trusted.
//   Comparator output is read unsynchronised, so it must settle
//   within two cycles of each tap change.
//   Tap code holds steady through a step, so the read is clean.
// Limitations
//   Cycle counts fit eight bits; longer codes need a wider counter.
//   No interrupt masking here; the end pulse is one cycle wide.
//   Step spreading assumes post-sample cycles of at least ten.
//   Speed code changes only by a mode write, which aborts first.
//   Channel code is read by the sample stage directly.
//   Results read zero until the first conversion completes.
//   Sampling time limits are left to software and clock choice.

module adc_ctrl (
    input wire mclk,
    input wire rst_n,
    input wire [15:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    input wire [7:0] bus_bit_mask,
    output reg [7:0] bus_rdata,
    input wire comparator_out,
    output reg comparator_power,
    output reg sample_hold,
    output reg [1:0] channel_code,
    output reg [9:0] approximation_register,
    output reg [9:0] result_10bit,
    output reg [7:0] result_upper_8bit,
    output reg conversion_end_irq,
    output reg conversion_active
);

    // State codes
    localparam ST_IDLE = 2'd0;
    localparam ST_SAMPLE = 2'd1;
    localparam ST_COMPARE = 2'd2;

    // ======================================================================
    // Speed code lookup
    // Sample length for a speed code
    function [7:0] sample_len;
        input [2:0] code;
        begin
            case (code)
                3'b000: sample_len = `SAMPLE_000;
                3'b100: sample_len = `SAMPLE_100;
                3'b110: sample_len = `SAMPLE_110;
                3'b101: sample_len = `SAMPLE_101;
                3'b010: sample_len = `SAMPLE_010;
                3'b001: sample_len = `SAMPLE_001;
                3'b111: sample_len = `SAMPLE_111;
                default: sample_len = `SAMPLE_011;
            endcase
        end
    endfunction

    // Total length for a speed code, sampling included
    function [7:0] total_len;
        input [2:0] code;
        begin
            case (code)
                3'b000: total_len = `TOTAL_000;
                3'b100: total_len = `TOTAL_100;
                3'b110: total_len = `TOTAL_110;
                3'b101: total_len = `TOTAL_101;
                3'b010: total_len = `TOTAL_010;
                3'b001: total_len = `TOTAL_001;
                3'b111: total_len = `TOTAL_111;
                default: total_len = `TOTAL_011;
            endcase
        end
    endfunction

    // Masked write: only bits set in the mask change
    function [7:0] merge_bits;
        input [7:0] old;
        input [7:0] data;
        input [7:0] mask;
        begin
            merge_bits = (old & ~mask) | (data & mask);
        end
    endfunction

    // ======================================================================
    // Registers and state
    reg [7:0] mode_reg;
    reg [1:0] state;
    reg [7:0] cycle_cnt;
    reg [3:0] bit_idx;
    reg [9:0] trial_bit;
    reg [7:0] cmp_len;
    reg [7:0] cmp_rem;
    reg [3:0] cmp_step;

    wire mode_wr = bus_wr && (bus_addr == `ADDR_MODE_CONTROL);
    wire chan_wr = bus_wr && (bus_addr == `ADDR_CHANNEL_SELECT);
    wire any_wr = mode_wr | chan_wr;
    wire [7:0] next_mode = merge_bits(mode_reg, bus_wdata,
        bus_bit_mask) & `MODE_WRITE_MASK;
    wire [7:0] next_chan = merge_bits({6'd0, channel_code}, bus_wdata,
        bus_bit_mask) & `CHAN_WRITE_MASK;
    wire run_bit = mode_reg[`MODE_RUN_BIT];
    wire [2:0] speed = mode_reg[`MODE_SPEED_HI:`MODE_SPEED_LO];
    // Post-sample cycles split over ten steps; remainder on the first steps
    wire [7:0] post_cycles = total_len(speed) - sample_len(speed);
    wire [7:0] base_step = post_cycles / 8'd10;
    wire [7:0] extra_steps = post_cycles - base_step * 8'd10;

    // ======================================================================
    // Register writes
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `REG_RESET;
            channel_code <= 2'b00;
        end else begin
            if (mode_wr) begin
                mode_reg <= next_mode;
            end
            if (chan_wr) begin
                channel_code <= next_chan[1:0];
            end
        end
    end

    // Read data; result registers and zeroed upper bits
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            if (bus_addr == `ADDR_MODE_CONTROL) begin
                bus_rdata <= mode_reg;
            end else if (bus_addr == `ADDR_CHANNEL_SELECT) begin
                bus_rdata <= {6'd0, channel_code};
            end else if (bus_addr == `ADDR_RESULT_LOW) begin
                bus_rdata <= result_10bit[7:0];
            end else if (bus_addr == `ADDR_RESULT_HIGH) begin
                bus_rdata <= {6'd0, result_10bit[9:8]};
            end else if (bus_addr == `ADDR_RESULT_UPPER) begin
                bus_rdata <= result_upper_8bit;
            end else begin
                bus_rdata <= 8'h00;
            end
        end
    end

    // ======================================================================
    // Conversion sequencer
    // Comparator power follows both bits; no static path when both clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            comparator_power <= 1'b0;
        end else begin
            comparator_power <= (mode_wr ? next_mode[`MODE_CMP_EN_BIT] |
                next_mode[`MODE_RUN_BIT] :
                mode_reg[`MODE_CMP_EN_BIT] | run_bit);
        end
    end

    // Sample, then ten timed comparisons from bit 9 downward
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cycle_cnt <= 8'd0;
            bit_idx <= 4'd0;
            trial_bit <= 10'd0;
            cmp_len <= 8'd0;
            cmp_rem <= 8'd0;
            cmp_step <= 4'd0;
            sample_hold <= 1'b0;
            approximation_register <= 10'd0;
            result_10bit <= 10'd0;
            result_upper_8bit <= 8'd0;
            conversion_end_irq <= 1'b0;
            conversion_active <= 1'b0;
        end else begin
            conversion_end_irq <= 1'b0;
            if (any_wr) begin
                // Abort; the new run bit restarts at sampling next cycle
                state <= ST_IDLE;
                sample_hold <= 1'b0;
                conversion_active <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (run_bit) begin
                            state <= ST_SAMPLE;
                            cycle_cnt <= sample_len(speed) - 8'd1;
                            sample_hold <= 1'b1;
                            conversion_active <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        if (cycle_cnt == 8'd0) begin
                            state <= ST_COMPARE;
                            sample_hold <= 1'b0;
                            bit_idx <= 4'd9;
                            trial_bit <= 10'h200;
                            approximation_register <= 10'h200;
                            cmp_len <= base_step;
                            cmp_rem <= extra_steps;
                            cmp_step <= 4'd0;
                            cycle_cnt <= base_step +
                                ((extra_steps != 8'd0) ? 8'd1 : 8'd0) -
                                8'd1;
                        end else begin
                            cycle_cnt <= cycle_cnt - 8'd1;
                        end
                    end
                    ST_COMPARE: begin
                        if (cycle_cnt != 8'd0) begin
                            cycle_cnt <= cycle_cnt - 8'd1;
                        end else begin
                            // Keep the trial bit when input >= tap
                            if (!comparator_out) begin
                                approximation_register <=
                                    (approximation_register & ~trial_bit) |
                                    (trial_bit >> 1);
                            end else begin
                                approximation_register <=
                                    approximation_register |
                                    (trial_bit >> 1);
                            end
                            trial_bit <= trial_bit >> 1;
                            cmp_step <= cmp_step + 4'd1;
                            cycle_cnt <= cmp_len +
                                (({4'd0, cmp_step} + 8'd1 < cmp_rem) ?
                                8'd1 : 8'd0) - 8'd1;
                            if (bit_idx == 4'd0) begin
                                result_10bit <= {approximation_register[9:1],
                                    comparator_out};
                                result_upper_8bit <=
                                    approximation_register[9:2];
                                conversion_end_irq <= 1'b1;
                                conversion_active <= 1'b0;
                                state <= ST_IDLE;
                            end else begin
                                bit_idx <= bit_idx - 4'd1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // adc_ctrl

// ===== logic/adc_ctrl_regs.vh
// Register map, field positions and timing counts of the converter control
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// ==========================================================================
// Register addresses
`define ADDR_MODE_CONTROL 16'hFF80
`define ADDR_CHANNEL_SELECT 16'hFF81
`define ADDR_RESULT_LOW 16'hFF18
`define ADDR_RESULT_HIGH 16'hFF19
`define ADDR_RESULT_UPPER 16'hFF1A

// ==========================================================================
// Mode register fields
`define MODE_RUN_BIT 7
`define MODE_SPEED_HI 5
`define MODE_SPEED_LO 3
`define MODE_CMP_EN_BIT 0
`define MODE_WRITE_MASK 8'hB9
`define CHAN_WRITE_MASK 8'h03
`define REG_RESET 8'h00

// ==========================================================================
// Sample and total conversion lengths in peripheral-clock cycles
`define SAMPLE_000 8'd12
`define TOTAL_000 8'd36
`define SAMPLE_100 8'd24
`define TOTAL_100 8'd72
`define SAMPLE_110 8'd96
`define TOTAL_110 8'd144
`define SAMPLE_101 8'd48
`define TOTAL_101 8'd96
`define SAMPLE_010 8'd48
`define TOTAL_010 8'd72
`define SAMPLE_001 8'd24
`define TOTAL_001 8'd48
`define SAMPLE_111 8'd176
`define TOTAL_111 8'd224
`define SAMPLE_011 8'd88
`define TOTAL_011 8'd112
`define RESULT_BITS 10

`endif

// ===== dv/adc_ctrl_monitor.sv
// Checker on the converter control ports
`timescale 1ns/1ps
module adc_ctrl_monitor (
    input wire mclk,
    input wire rst_n,
    input wire [15:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    input wire [7:0] bus_bit_mask,
    input wire [7:0] bus_rdata,
    input wire sample_hold,
    input wire conversion_active,
    input wire comparator_power,
    input wire [1:0] channel_code,
    input wire [9:0] result_10bit,
    input wire [7:0] result_upper_8bit,
    input wire conversion_end_irq
);
    // ==========================================
    // Writes to the two control registers
    wire mw = bus_wr && bus_addr == 16'hFF80;
    wire cw = bus_wr && bus_addr == 16'hFF81;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Completion, result copies and aborts
    chk_irq_pulse: assert property (
        conversion_end_irq |=> !conversion_end_irq) else $error("irq long");
    chk_upper_copy: assert property (
        conversion_end_irq |-> result_upper_8bit == result_10bit[9:2])
        else $error("upper result differs");
    chk_write_abort: assert property (
        mw || cw |=> !conversion_active) else $error("no abort");
    chk_sample_inside: assert property (
        sample_hold |-> conversion_active) else $error("sample outside");
    // Run bit, power state and register contents
    chk_run_start: assert property (
        mw && bus_bit_mask[7] && bus_wdata[7] |-> ##[1:3] sample_hold)
        else $error("run did not start");
    chk_stop_run: assert property (
        mw && bus_bit_mask[7] && !bus_wdata[7] |-> ##3 !conversion_active)
        else $error("run did not stop");
    chk_full_stop: assert property (
        mw && bus_bit_mask == 8'hFF && bus_wdata == 8'h00
        |-> ##3 !comparator_power) else $error("power left on");
    chk_mode_zero: assert property (
        bus_rd && bus_addr == 16'hFF80 |=> bus_rdata[6] == 1'b0
        && bus_rdata[2:1] == 2'b00) else $error("fixed bits set");
    chk_chan_write: assert property (
        cw && bus_bit_mask == 8'hFF |=> channel_code == $past(bus_wdata[1:0]))
        else $error("channel not taken");
endmodule // adc_ctrl_monitor

// ===== dv/adc_analog_model.sv
// Behavioural sample-and-hold, tap array and comparator
`timescale 1ns/1ps
module adc_analog_model (
    input wire mclk,
    input wire [39:0] vin,
    input wire [1:0] channel_code,
    input wire sample_hold,
    input wire comparator_power,
    input wire [9:0] approximation_register,
    output wire comparator_out
);
    // ==========================================
    reg [9:0] held = 10'h000;
    reg junk = 1'b0;
    // Track the input while sampling, freeze once hold starts
    always @(posedge mclk) begin
        junk <= ~junk;
        if (sample_hold)
            held <= vin[channel_code*10 +: 10];
    end
    // Unpowered comparator toggles, so a stale zero cannot pass
    assign comparator_out = comparator_power ?
        (held >= approximation_register) : junk;
endmodule // adc_analog_model

// ===== dv/tb_adc_ctrl.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_adc_ctrl;
    // ==========================================
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg bus_wr = 1'b0;
    reg bus_rd = 1'b0;
    reg [15:0] bus_addr = 16'h0000;
    reg [7:0] bus_wdata = 8'h00;
    reg [7:0] bus_bit_mask = 8'h00;
    reg [39:0] vin = 40'h0;
    reg [7:0] rv;
    wire [7:0] bus_rdata, result_upper_8bit;
    wire [9:0] approximation_register, result_10bit;
    wire [1:0] channel_code;
    wire comparator_out, comparator_power, sample_hold;
    wire conversion_end_irq, conversion_active;
    integer err_count = 0;
    integer compares = 0;
    integer seed = 32'hf42bf81c;
    integer i, s, t, ch, c;
    // Sample and total lengths, code 7 down to 0
    localparam [63:0] smp_tab = {8'd176, 8'd96, 8'd48, 8'd24,
        8'd88, 8'd48, 8'd24, 8'd12};
    localparam [63:0] tot_tab = {8'd224, 8'd144, 8'd96, 8'd72,
        8'd112, 8'd72, 8'd48, 8'd36};
    always #2.5 mclk = ~mclk;
    adc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_bit_mask(bus_bit_mask), .bus_rdata(bus_rdata),
        .comparator_out(comparator_out), .sample_hold(sample_hold),
        .comparator_power(comparator_power), .channel_code(channel_code),
        .approximation_register(approximation_register),
        .result_10bit(result_10bit), .result_upper_8bit(result_upper_8bit),
        .conversion_end_irq(conversion_end_irq),
        .conversion_active(conversion_active));
    adc_analog_model far (.mclk(mclk), .vin(vin), .sample_hold(sample_hold),
        .channel_code(channel_code), .comparator_power(comparator_power),
        .approximation_register(approximation_register),
        .comparator_out(comparator_out));
    // ==========================================
    task stop_test;
        begin
            $display("errors %0d compares %0d", err_count, compares);
            if (err_count == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // Bus strobes last one cycle, changed on the falling edge
    task wr(input [15:0] a, input [7:0] d, input [7:0] m);
        begin
            @(negedge mclk);
            bus_addr = a;
            bus_wdata = d;
            bus_bit_mask = m;
            bus_wr = 1'b1;
            @(negedge mclk);
            bus_wr = 1'b0;
        end
    endtask
    task rd(input [15:0] a, output [7:0] d);
        begin
            @(negedge mclk);
            bus_addr = a;
            bus_rd = 1'b1;
            @(negedge mclk);
            bus_rd = 1'b0;
            d = bus_rdata;
        end
    endtask
    // Time one conversion; g is low when its result is to be dropped
    task conv(input [2:0] k, input g);
        begin
            s = 0;
            t = 0;
            for (i = 0; i < 300 && sample_hold !== 1'b1; i = i + 1)
                @(negedge mclk);
            while (conversion_active === 1'b1 && t < 300) begin
                if (sample_hold === 1'b1)
                    s = s + 1;
                t = t + 1;
                @(negedge mclk);
            end
            if (i >= 300 || t >= 300) begin
                err_count = err_count + 1;
                stop_test;
            end else begin
                chk("sample", smp_tab[k*8 +: 8], s[15:0]);
                chk("total", tot_tab[k*8 +: 8], t[15:0]);
                chk("irq", 1'b1, conversion_end_irq);
                chk("channel", ch[1:0], channel_code);
                if (g)
                    chk("result", vin[ch*10 +: 10], result_10bit);
            end
        end
    endtask
    // ==========================================
    initial begin
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        rd(16'hFF80, rv);
        chk("mode", 8'h00, rv);
        rd(16'h1234, rv);
        chk("unmapped", 8'h00, rv);
        wr(16'hFF80, 8'h7F, 8'hFF);
        rd(16'hFF80, rv);
        chk("mode", 8'h39, rv);
        wr(16'hFF81, 8'hFF, 8'hFF);
        rd(16'hFF81, rv);
        chk("chan", 8'h03, rv);
        wr(16'hFF81, 8'h00, 8'h02);
        rd(16'hFF81, rv);
        chk("chanbit", 8'h01, rv);
        repeat (200) @(negedge mclk);
        // Every speed code, random inputs, two back-to-back results
        for (c = 0; c < 8; c = c + 1) begin
            ch = $random(seed) & 3;
            vin[31:0] = $random(seed);
            rv = $random(seed);
            vin[39:32] = rv;
            wr(16'hFF80, 8'h01, 8'hFF);
            wr(16'hFF81, ch[7:0], 8'hFF);
            wr(16'hFF80, {2'b00, c[2:0], 3'b001}, 8'hFF);
            repeat (4) @(negedge mclk);
            wr(16'hFF80, 8'h80, 8'h80);
            conv(c[2:0], 1'b1);
            conv(c[2:0], 1'b1);
        end
        // Channel write in the compare phase restarts from sampling
        repeat (200) @(negedge mclk);
        ch = 1;
        wr(16'hFF81, 8'h01, 8'hFF);
        chk("abort", 1'b0, conversion_active);
        conv(3'd7, 1'b1);
        // Full stop, then run with the comparator off
        wr(16'hFF80, 8'h00, 8'hFF);
        repeat (3) @(negedge mclk);
        chk("power", 1'b0, comparator_power);
        wr(16'hFF80, 8'h80, 8'h80);
        conv(3'd0, 1'b0);
        conv(3'd0, 1'b1);
        wr(16'hFF80, 8'h01, 8'hFF);
        repeat (3) @(negedge mclk);
        chk("power", 1'b1, comparator_power);
        chk("active", 1'b0, conversion_active);
        rd(16'hFF18, rv);
        chk("low", vin[ch*10 +: 8], rv);
        rd(16'hFF19, rv);
        chk("high", {6'b0, vin[ch*10+8 +: 2]}, rv);
        rd(16'hFF1A, rv);
        chk("upper", vin[ch*10+2 +: 8], rv);
        stop_test;
    end
endmodule // tb_adc_ctrl
bind adc_ctrl adc_ctrl_monitor mon (.mclk(mclk), .rst_n(rst_n),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_bit_mask(bus_bit_mask),
    .bus_rdata(bus_rdata), .sample_hold(sample_hold),
    .conversion_active(conversion_active),
    .comparator_power(comparator_power), .channel_code(channel_code),
    .result_10bit(result_10bit), .result_upper_8bit(result_upper_8bit),
    .conversion_end_irq(conversion_end_irq));
